/* File: rtl/irq_flag_regs.svh */
`ifndef IRQ_FLAG_REGS_SVH
`define IRQ_FLAG_REGS_SVH
`define IRQF_REG_W 8
`define IRQF_IDX_W 12
`define IRQF_ADDR_LSB 2
`define IRQF_IDX_LOGIC 12'h711
`define IRQF_IDX_CAPCMP 12'h712
`define IRQF_IDX_MISC 12'h713
`define IRQF_IDX_MEAS 12'h714
`define IRQF_IDX_MASK_LOGIC 12'h720
`define IRQF_IDX_MASK_CAPCMP 12'h721
`define IRQF_IDX_MASK_MISC 12'h722
`define IRQF_IDX_MASK_MEAS 12'h723
`define IRQF_IDX_MODE 12'h724
`define IRQF_LOGIC_IMPL 8'hF7
`define IRQF_CAPCMP_IMPL 8'h0F
`define IRQF_MISC_IMPL 8'h33
`define IRQF_MEAS_IMPL 8'h07
`define IRQF_FLAG_RST 8'h00
`define IRQF_MASK_RST 8'h00
`define IRQF_MODE_RST 8'h00
`define IRQF_LOGIC_CELL_LSB 4
`define IRQF_GATE_LSB 0
`define IRQF_CAPCMP_LSB 0
`define IRQF_NVM_BIT 5
`define IRQF_NCO_BIT 4
`define IRQF_WAVEGEN_LSB 0
`define IRQF_PULSE_BIT 2
`define IRQF_PERIOD_BIT 1
`define IRQF_MEAS_BIT 0
`define IRQF_MODE_W 2
`define AHB_TRANS_NONSEQ 2'h2
`define AHB_TRANS_SEQ 2'h3
`define AHB_SIZE_WORD 3'h2
`define AHB_RESP_OKAY 1'h0
`endif

/* File: rtl/irq_flag_pkg.sv */
package irq_flag_pkg;
  typedef enum logic [1:0] {CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM} ccp_mode_t;
  typedef enum logic [1:0] {EVT_PULSE, EVT_RISE, EVT_FALL} edge_kind_t;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_LOGIC, SEL_CAPCMP, SEL_MISC, SEL_MEAS, SEL_MASK_LOGIC,
    SEL_MASK_CAPCMP, SEL_MASK_MISC, SEL_MASK_MEAS, SEL_MODE
  } reg_sel_t;
endpackage

/* File: rtl/event_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module event_edge_detect #(
  parameter int W = 1,
  parameter irq_flag_pkg::edge_kind_t KIND = irq_flag_pkg::EVT_PULSE
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_sig,
  output logic [W-1:0] o_event
);
  import irq_flag_pkg::*;
  typedef struct packed {
    logic [W-1:0] prev;
  } edge_state_t;
  edge_state_t cur;
  edge_state_t next_state;

  always_comb begin
    next_state = cur;
    next_state.prev = i_sig;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cur <= '0;
    end else if (i_clk_en) begin
      cur <= next_state;
    end
  end

  // prev resets low: a level already high at reset counts as a rise
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (KIND == EVT_RISE) begin : g_rise
      assign o_event[i] = i_sig[i] & ~cur.prev[i];
    end else if (KIND == EVT_FALL) begin : g_fall
      assign o_event[i] = ~i_sig[i] & cur.prev[i];
    end else begin : g_pulse
      assign o_event[i] = i_sig[i];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/peripheral_irq_flag_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "irq_flag_regs.svh"
// Overview of operation
// - each logic-cell flag sets on that cell's interrupt condition and holds until cleared.
// - each timer gate flag sets when its gate goes inactive, marking a finished acquisition.
// - a capture/compare unit in capture mode sets its flag on each capture and holds it.
// - a capture/compare unit in compare mode sets its flag on a match and holds it.
// - a capture/compare unit in PWM mode sets its flag on each output trailing edge.
// - the memory-operation flag sets when a requested memory operation completes.
// - the accumulator-oscillator flag sets on every oscillator rollover.
// - each waveform flag sets on entry to shutdown and holds until cleared, even after a return to normal run.
// - the measure timer sets its pulse-width flag on that acquisition and holds it.
// - the measure timer sets its period flag on that acquisition and holds it.
// - the general measure timer flag sets on its event and clears only by a software write.
// - every flag sets on its event whatever the enable bits say.
module peripheral_irq_flag_bank #(
  parameter int ADDR_W = 16,
  parameter int NUM_LOGIC_CELLS = 4,
  parameter int NUM_GATES = 3,
  parameter int NUM_CAPCMP = 4,
  parameter int NUM_WAVEGEN = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [ADDR_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  output logic o_irq,
  input wire logic [NUM_LOGIC_CELLS-1:0] i_logic_cell_irq,
  input wire logic [NUM_GATES-1:0] i_timer_gate_open,
  input wire logic [NUM_CAPCMP-1:0] i_capcmp_capture,
  input wire logic [NUM_CAPCMP-1:0] i_capcmp_match,
  input wire logic [NUM_CAPCMP-1:0] i_capcmp_pwm_out,
  input wire logic i_memory_op_done,
  input wire logic i_accum_osc_rollover,
  input wire logic [NUM_WAVEGEN-1:0] i_wavegen_shutdown,
  input wire logic i_measure_pulse_width,
  input wire logic i_measure_period,
  input wire logic i_measure_timer_event
);
  import irq_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [`IRQF_REG_W-1:0] flag_logic;
    logic [`IRQF_REG_W-1:0] flag_capcmp;
    logic [`IRQF_REG_W-1:0] flag_misc;
    logic [`IRQF_REG_W-1:0] flag_meas;
    logic [`IRQF_REG_W-1:0] mask_logic;
    logic [`IRQF_REG_W-1:0] mask_capcmp;
    logic [`IRQF_REG_W-1:0] mask_misc;
    logic [`IRQF_REG_W-1:0] mask_meas;
    logic [`IRQF_REG_W-1:0] mode;
    reg_sel_t wsel;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic irq;
  } state_t;

  localparam state_t RST_STATE = '{
    flag_logic: `IRQF_FLAG_RST,
    flag_capcmp: `IRQF_FLAG_RST,
    flag_misc: `IRQF_FLAG_RST,
    flag_meas: `IRQF_FLAG_RST,
    mask_logic: `IRQF_MASK_RST,
    mask_capcmp: `IRQF_MASK_RST,
    mask_misc: `IRQF_MASK_RST,
    mask_meas: `IRQF_MASK_RST,
    mode: `IRQF_MODE_RST,
    wsel: SEL_NONE,
    rdata: 32'h0000_0000,
    ready: 1'h1,
    resp: `AHB_RESP_OKAY,
    irq: 1'h0
  };

  state_t cur;
  state_t next_state;
  logic [`IRQF_REG_W-1:0] set_logic;
  logic [`IRQF_REG_W-1:0] set_capcmp;
  logic [`IRQF_REG_W-1:0] set_misc;
  logic [`IRQF_REG_W-1:0] set_meas;
  logic [`IRQF_REG_W-1:0] clr_logic;
  logic [`IRQF_REG_W-1:0] clr_capcmp;
  logic [`IRQF_REG_W-1:0] clr_misc;
  logic [`IRQF_REG_W-1:0] clr_meas;
  logic [`IRQF_REG_W-1:0] wdata;
  logic [NUM_CAPCMP-1:0] ccp_evt;
  logic [NUM_CAPCMP-1:0] pwm_fall;
  logic [NUM_GATES-1:0] gate_fall;
  logic [NUM_WAVEGEN-1:0] wavegen_rise;
  logic [`IRQF_IDX_W-1:0] idx;
  logic hit;
  logic take;
  reg_sel_t sel;

  ////////////////////////////////////////////////////////////////////////////
  function automatic reg_sel_t decode(input logic [`IRQF_IDX_W-1:0] a);
    case (a)
      `IRQF_IDX_LOGIC: decode = SEL_LOGIC;
      `IRQF_IDX_CAPCMP: decode = SEL_CAPCMP;
      `IRQF_IDX_MISC: decode = SEL_MISC;
      `IRQF_IDX_MEAS: decode = SEL_MEAS;
      `IRQF_IDX_MASK_LOGIC: decode = SEL_MASK_LOGIC;
      `IRQF_IDX_MASK_CAPCMP: decode = SEL_MASK_CAPCMP;
      `IRQF_IDX_MASK_MISC: decode = SEL_MASK_MISC;
      `IRQF_IDX_MASK_MEAS: decode = SEL_MASK_MEAS;
      `IRQF_IDX_MODE: decode = SEL_MODE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // unmapped and reserved read as zero
  function automatic logic [`IRQF_REG_W-1:0] read_mux(input reg_sel_t s, input state_t st);
    case (s)
      SEL_LOGIC: read_mux = st.flag_logic;
      SEL_CAPCMP: read_mux = st.flag_capcmp;
      SEL_MISC: read_mux = st.flag_misc;
      SEL_MEAS: read_mux = st.flag_meas;
      SEL_MASK_LOGIC: read_mux = st.mask_logic;
      SEL_MASK_CAPCMP: read_mux = st.mask_capcmp;
      SEL_MASK_MISC: read_mux = st.mask_misc;
      SEL_MASK_MEAS: read_mux = st.mask_meas;
      SEL_MODE: read_mux = st.mode;
      default: read_mux = `IRQF_FLAG_RST;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  event_edge_detect #(
    .W(NUM_CAPCMP + NUM_GATES),
    .KIND(EVT_FALL)
  ) u_fall_detect (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_sig({i_capcmp_pwm_out, i_timer_gate_open}),
    .o_event({pwm_fall, gate_fall})
  );

  event_edge_detect #(
    .W(NUM_WAVEGEN),
    .KIND(EVT_RISE)
  ) u_rise_detect (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_sig(i_wavegen_shutdown),
    .o_event(wavegen_rise)
  );

  // each unit's mode picks which of its three events reaches the flag
  for (genvar u = 0; u < NUM_CAPCMP; u++) begin : g_capcmp
    ccp_mode_t m;
    assign m = ccp_mode_t'(cur.mode[u*`IRQF_MODE_W +: `IRQF_MODE_W]);
    assign ccp_evt[u] = ((m == CCP_CAPTURE) & i_capcmp_capture[u])
                      | ((m == CCP_COMPARE) & i_capcmp_match[u])
                      | ((m == CCP_PWM) & pwm_fall[u]);
  end

  ////////////////////////////////////////////////////////////////////////////
  assign idx = i_haddr[`IRQF_IDX_W+`IRQF_ADDR_LSB-1:`IRQF_ADDR_LSB];
  assign hit = ((i_haddr >> (`IRQF_IDX_W + `IRQF_ADDR_LSB)) == '0)
            && (i_haddr[`IRQF_ADDR_LSB-1:0] == '0);
  assign take = i_hsel && i_hready && i_hsize == `AHB_SIZE_WORD
             && (i_htrans == `AHB_TRANS_NONSEQ || i_htrans == `AHB_TRANS_SEQ);
  assign sel = hit ? decode(idx) : SEL_NONE;
  assign wdata = i_hwdata[`IRQF_REG_W-1:0];

  always_comb begin
    next_state = cur;
    set_logic = '0;
    set_capcmp = '0;
    set_misc = '0;
    set_meas = '0;
    // enables play no part in setting
    set_logic[`IRQF_LOGIC_CELL_LSB +: NUM_LOGIC_CELLS] = i_logic_cell_irq;
    set_logic[`IRQF_GATE_LSB +: NUM_GATES] = gate_fall;
    set_capcmp[`IRQF_CAPCMP_LSB +: NUM_CAPCMP] = ccp_evt;
    set_misc[`IRQF_NVM_BIT] = i_memory_op_done;
    set_misc[`IRQF_NCO_BIT] = i_accum_osc_rollover;
    set_misc[`IRQF_WAVEGEN_LSB +: NUM_WAVEGEN] = wavegen_rise;
    set_meas[`IRQF_PULSE_BIT] = i_measure_pulse_width;
    set_meas[`IRQF_PERIOD_BIT] = i_measure_period;
    set_meas[`IRQF_MEAS_BIT] = i_measure_timer_event;
    // write-one-to-clear in the data phase
    clr_logic = (cur.wsel == SEL_LOGIC) ? wdata : '0;
    clr_capcmp = (cur.wsel == SEL_CAPCMP) ? wdata : '0;
    clr_misc = (cur.wsel == SEL_MISC) ? wdata : '0;
    clr_meas = (cur.wsel == SEL_MEAS) ? wdata : '0;
    // set after clear so a same-cycle event survives
    next_state.flag_logic = ((cur.flag_logic & ~clr_logic) | set_logic)
                          & `IRQF_LOGIC_IMPL;
    next_state.flag_capcmp = ((cur.flag_capcmp & ~clr_capcmp) | set_capcmp)
                           & `IRQF_CAPCMP_IMPL;
    next_state.flag_misc = ((cur.flag_misc & ~clr_misc) | set_misc)
                         & `IRQF_MISC_IMPL;
    next_state.flag_meas = ((cur.flag_meas & ~clr_meas) | set_meas)
                         & `IRQF_MEAS_IMPL;
    case (cur.wsel)
      SEL_MASK_LOGIC: next_state.mask_logic = wdata & `IRQF_LOGIC_IMPL;
      SEL_MASK_CAPCMP: next_state.mask_capcmp = wdata & `IRQF_CAPCMP_IMPL;
      SEL_MASK_MISC: next_state.mask_misc = wdata & `IRQF_MISC_IMPL;
      SEL_MASK_MEAS: next_state.mask_meas = wdata & `IRQF_MEAS_IMPL;
      SEL_MODE: next_state.mode = wdata;
      default: next_state.mode = cur.mode;
    endcase
    // read data is taken from the updated copy so a read right after a
    // write already sees that write, with no wait state
    next_state.wsel = (take && i_hwrite) ? sel : SEL_NONE;
    next_state.rdata = 32'h0000_0000;
    if (take && !i_hwrite) begin
      next_state.rdata[`IRQF_REG_W-1:0] = read_mux(sel, next_state);
    end
    next_state.ready = 1'h1;
    next_state.resp = `AHB_RESP_OKAY;
    next_state.irq = |{next_state.flag_logic & next_state.mask_logic,
                       next_state.flag_capcmp & next_state.mask_capcmp,
                       next_state.flag_misc & next_state.mask_misc,
                       next_state.flag_meas & next_state.mask_meas};
  end

  // clock enable low freezes everything, the bus answer included
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cur <= RST_STATE;
    end else if (i_clk_en) begin
      cur <= next_state;
    end
  end

  assign o_hreadyout = cur.ready;
  assign o_hrdata = cur.rdata;
  assign o_hresp = cur.resp;
  assign o_irq = cur.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_logic_set;
    i_clk_en && i_logic_cell_irq[0] |=> cur.flag_logic[`IRQF_LOGIC_CELL_LSB];
  endproperty
  a_logic_set: assert property (p_logic_set)
    else $error("logic cell flag not set");

  property p_logic_hold;
    cur.flag_logic[`IRQF_LOGIC_CELL_LSB] && !clr_logic[`IRQF_LOGIC_CELL_LSB]
      |=> cur.flag_logic[`IRQF_LOGIC_CELL_LSB];
  endproperty
  a_logic_hold: assert property (p_logic_hold)
    else $error("logic cell flag lost without clear");

  property p_gate_set;
    i_clk_en && $past(i_clk_en) && $fell(i_timer_gate_open[0])
      |=> cur.flag_logic[`IRQF_GATE_LSB];
  endproperty
  a_gate_set: assert property (p_gate_set)
    else $error("gate flag not set on gate close");

  property p_capture_set;
    i_clk_en && cur.mode[1:0] == CCP_CAPTURE && i_capcmp_capture[0]
      |=> cur.flag_capcmp[`IRQF_CAPCMP_LSB];
  endproperty
  a_capture_set: assert property (p_capture_set)
    else $error("capture flag not set");

  property p_compare_set;
    i_clk_en && cur.mode[3:2] == CCP_COMPARE && i_capcmp_match[1]
      |=> cur.flag_capcmp[`IRQF_CAPCMP_LSB+1];
  endproperty
  a_compare_set: assert property (p_compare_set)
    else $error("compare flag not set");

  property p_pwm_set;
    i_clk_en && $past(i_clk_en) && cur.mode[1:0] == CCP_PWM
      && $fell(i_capcmp_pwm_out[0]) |=> cur.flag_capcmp[`IRQF_CAPCMP_LSB];
  endproperty
  a_pwm_set: assert property (p_pwm_set)
    else $error("pwm trailing edge flag not set");

  property p_nvm_set;
    i_clk_en && i_memory_op_done ##1 !clr_misc[`IRQF_NVM_BIT]
      |=> cur.flag_misc[`IRQF_NVM_BIT];
  endproperty
  a_nvm_set: assert property (p_nvm_set)
    else $error("memory flag not set or not held");

  property p_nco_set;
    i_clk_en && i_accum_osc_rollover |=> cur.flag_misc[`IRQF_NCO_BIT];
  endproperty
  a_nco_set: assert property (p_nco_set)
    else $error("oscillator rollover flag not set");

  property p_wavegen_set;
    i_clk_en && $past(i_clk_en) && $rose(i_wavegen_shutdown[0])
      |=> cur.flag_misc[`IRQF_WAVEGEN_LSB];
  endproperty
  a_wavegen_set: assert property (p_wavegen_set)
    else $error("shutdown flag not set");

  property p_wavegen_clear;
    i_clk_en && clr_misc[`IRQF_WAVEGEN_LSB] && !wavegen_rise[0]
      |=> !cur.flag_misc[`IRQF_WAVEGEN_LSB];
  endproperty
  a_wavegen_clear: assert property (p_wavegen_clear)
    else $error("shutdown flag not cleared");

  property p_pulse_set;
    i_clk_en && i_measure_pulse_width |=> cur.flag_meas[`IRQF_PULSE_BIT];
  endproperty
  a_pulse_set: assert property (p_pulse_set)
    else $error("pulse width flag not set");

  property p_period_set;
    i_clk_en && i_measure_period |=> cur.flag_meas[`IRQF_PERIOD_BIT];
  endproperty
  a_period_set: assert property (p_period_set)
    else $error("period flag not set");

  property p_meas_clear_only_sw;
    $fell(cur.flag_meas[`IRQF_MEAS_BIT]) |-> $past(clr_meas[`IRQF_MEAS_BIT]);
  endproperty
  a_meas_clear_only_sw: assert property (p_meas_clear_only_sw)
    else $error("measure flag fell without a write");

  property p_set_unmasked;
    i_clk_en && i_memory_op_done && cur.mask_misc == '0
      |=> cur.flag_misc[`IRQF_NVM_BIT] && ($rose(cur.flag_misc[`IRQF_NVM_BIT])
          || $past(cur.flag_misc[`IRQF_NVM_BIT]));
  endproperty
  a_set_unmasked: assert property (p_set_unmasked)
    else $error("masked flag did not set");

  property p_reserved_zero;
    ((cur.flag_logic & ~`IRQF_LOGIC_IMPL) | (cur.flag_capcmp & ~`IRQF_CAPCMP_IMPL)
      | (cur.flag_misc & ~`IRQF_MISC_IMPL) | (cur.flag_meas & ~`IRQF_MEAS_IMPL)) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved flag bit set");

  property p_set_beats_clear;
    i_clk_en && i_memory_op_done && clr_misc[`IRQF_NVM_BIT]
      |=> cur.flag_misc[`IRQF_NVM_BIT];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("set lost against clear");

  property p_irq_level;
    o_irq == |{cur.flag_logic & cur.mask_logic, cur.flag_capcmp & cur.mask_capcmp,
               cur.flag_misc & cur.mask_misc, cur.flag_meas & cur.mask_meas};
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with flags");
endmodule
`default_nettype wire

/* File: test/irq_event_source.sv */
`timescale 1ns/100ps
`default_nettype none
module irq_event_source (
  input wire logic i_clk,
  output logic [3:0] o_logic_cell_irq,
  output logic [2:0] o_timer_gate_open,
  output logic [3:0] o_capcmp_capture,
  output logic [3:0] o_capcmp_match,
  output logic [3:0] o_capcmp_pwm_out,
  output logic o_memory_op_done,
  output logic o_accum_osc_rollover,
  output logic [1:0] o_wavegen_shutdown,
  output logic o_measure_pulse_width,
  output logic o_measure_period,
  output logic o_measure_timer_event
);
  logic [25:0] pulse_q = '0;
  logic [1:0] shut_q = '0;
  assign o_logic_cell_irq = pulse_q[3:0];
  // gate open for one cycle, then inactive: acquisition done
  assign o_timer_gate_open = pulse_q[6:4];
  assign o_capcmp_capture = pulse_q[10:7];
  assign o_capcmp_match = pulse_q[14:11];
  // output high one cycle, the drop is the trailing edge
  assign o_capcmp_pwm_out = pulse_q[18:15];
  assign o_memory_op_done = pulse_q[19];
  assign o_accum_osc_rollover = pulse_q[20];
  // shutdown entry, briefly or held
  assign o_wavegen_shutdown = pulse_q[22:21] | shut_q;
  assign o_measure_pulse_width = pulse_q[23];
  assign o_measure_period = pulse_q[24];
  assign o_measure_timer_event = pulse_q[25];
  task automatic fire(input int code);
    pulse_q[code] <= 1'b1;
    @(posedge i_clk);
    pulse_q[code] <= 1'b0;
  endtask
  task automatic hold_shutdown(input int unit, input logic on);
    shut_q[unit] <= on;
  endtask
endmodule
`default_nettype wire

/* File: test/peripheral_irq_flag_bank_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "irq_flag_regs.svh"
module peripheral_irq_flag_bank_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [15:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  wire logic hrdy, hresp, irq, mem, osc, pw, per, tmr;
  wire logic [31:0] hrdata;
  wire logic [3:0] lc, cap, mat, pwm;
  wire logic [2:0] gate;
  wire logic [1:0] shut;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  peripheral_irq_flag_bank dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp), .o_irq(irq),
    .i_logic_cell_irq(lc), .i_timer_gate_open(gate), .i_capcmp_capture(cap),
    .i_capcmp_match(mat), .i_capcmp_pwm_out(pwm), .i_memory_op_done(mem),
    .i_accum_osc_rollover(osc), .i_wavegen_shutdown(shut), .i_measure_pulse_width(pw),
    .i_measure_period(per), .i_measure_timer_event(tmr)
  );
  irq_event_source src_u (
    .i_clk(clk), .o_logic_cell_irq(lc), .o_timer_gate_open(gate), .o_capcmp_capture(cap),
    .o_capcmp_match(mat), .o_capcmp_pwm_out(pwm), .o_memory_op_done(mem),
    .o_accum_osc_rollover(osc), .o_wavegen_shutdown(shut), .o_measure_pulse_width(pw),
    .o_measure_period(per), .o_measure_timer_event(tmr)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hready sampled at the edge, before that edge's updates land
  task automatic wait_ready;
    int k;
    @(posedge clk);
    for (k = 0; k < 64 && hrdy !== 1'b1; k++) @(posedge clk);
    if (k == 64) begin
      n_fail++;
      $display("[ERR] %0t bus hang", $time);
      test_done();
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= `AHB_TRANS_NONSEQ;
    hwrite <= wr;
    hsize <= `AHB_SIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk(x, 32'(e));
  endtask
  task automatic ev(input int c);
    src_u.fire(c);
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [11:0] reg_of(input int c);
    if (c < 7) return `IRQF_IDX_LOGIC;
    if (c < 19) return `IRQF_IDX_CAPCMP;
    if (c < 23) return `IRQF_IDX_MISC;
    return `IRQF_IDX_MEAS;
  endfunction
  function automatic logic [7:0] bit_of(input int c);
    int b;
    b = (c < 4) ? c + 4 : (c < 7) ? c - 4 : (c < 19) ? (c - 7) % 4 :
        (c == 19) ? 5 : (c == 20) ? 4 : (c < 23) ? c - 21 : 25 - c;
    return 8'(1 << b);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [11:0] regs [9];
    regs = '{12'h711, 12'h712, 12'h713, 12'h714, 12'h720, 12'h721, 12'h722, 12'h723, 12'h724};
    for (int i = 0; i < 9; i++) rdc(regs[i], 8'h00);
    rdc(12'h700, 8'h00);
    chk({29'h0, hrdy, hresp, irq}, 32'h0000_0004);
  endtask
  task automatic t_reserved;
    logic [7:0] impl [4];
    impl = '{`IRQF_LOGIC_IMPL, `IRQF_CAPCMP_IMPL, `IRQF_MISC_IMPL, `IRQF_MEAS_IMPL};
    for (int i = 0; i < 4; i++) begin
      wr(12'h711 + 12'(i), 8'hff);
      rdc(12'h711 + 12'(i), 8'h00);
      wr(12'h720 + 12'(i), 8'hff);
      rdc(12'h720 + 12'(i), impl[i]);
      wr(12'h720 + 12'(i), 8'h00);
    end
  endtask
  // every non-unit flag: set with masks off, held, write 0 ignored, write 1 clears
  task automatic t_flags;
    for (int c = 0; c < 26; c++) begin
      if (c < 7 || c > 18) begin
        ev(c);
        rdc(reg_of(c), bit_of(c));
        wr(reg_of(c), 8'h00);
        rdc(reg_of(c), bit_of(c));
        wr(reg_of(c), bit_of(c));
        rdc(reg_of(c), 8'h00);
      end
    end
    src_u.hold_shutdown(1, 1'b1);
    repeat (3) @(posedge clk);
    rdc(`IRQF_IDX_MISC, 8'h02);
    wr(`IRQF_IDX_MISC, 8'h02);
    rdc(`IRQF_IDX_MISC, 8'h00);
    src_u.hold_shutdown(1, 1'b0);
  endtask
  task automatic t_capcmp;
    logic [7:0] m;
    for (int md = 0; md < 4; md++) begin
      m = {4{2'(md)}};
      wr(`IRQF_IDX_MODE, m);
      rdc(`IRQF_IDX_MODE, m);
      for (int c = 7; c < 19; c++) begin
        ev(c);
        rdc(`IRQF_IDX_CAPCMP, ((c - 7) / 4 + 1 == md) ? bit_of(c) : 8'h00);
        wr(`IRQF_IDX_CAPCMP, 8'h0f);
      end
    end
  endtask
  task automatic t_irq;
    rdc(`IRQF_IDX_MISC, 8'h00);
    wr(`IRQF_IDX_MASK_MISC, 8'h20);
    ev(20);
    chk(32'(irq), 32'h0);
    ev(19);
    chk(32'(irq), 32'h1);
    wr(`IRQF_IDX_MASK_MISC, 8'h00);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(`IRQF_IDX_MASK_MISC, 8'h20);
    @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(`IRQF_IDX_MISC, 8'h30);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(`IRQF_IDX_MASK_MISC, 8'h00);
  endtask
  // event sampled at the very edge that applies the clear
  task automatic t_race;
    ev(19);
    fork
      wr(`IRQF_IDX_MISC, 8'h20);
      begin
        @(posedge clk);
        src_u.fire(19);
      end
    join
    repeat (2) @(posedge clk);
    rdc(`IRQF_IDX_MISC, 8'h20);
    wr(`IRQF_IDX_MISC, 8'h20);
    rdc(`IRQF_IDX_MISC, 8'h00);
  endtask
  // frozen clock enable drops events; a reset in mid-run clears a set flag
  task automatic t_freeze;
    clk_en <= 1'b0;
    ev(20);
    clk_en <= 1'b1;
    rdc(`IRQF_IDX_MISC, 8'h00);
    ev(20);
    rdc(`IRQF_IDX_MISC, 8'h10);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(`IRQF_IDX_MISC, 8'h00);
    chk({31'h0, irq}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_reserved();
    t_flags();
    t_capcmp();
    t_irq();
    t_race();
    t_freeze();
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
